// File: src/l2ih_top.sv
// Second-level interrupt handler for 32 active-low request lines.
// Assumes a single-cycle private register port on ref_clk and a
// clock manager that idles the block through idle_req/idle_ack.
// Function
// - Pending flags reset zero, set on any request.
// - Writing zero clears a pending bit; one keeps.
// - Mask register resets all ones, one blocks.
// - Mask acts after pending flags are recorded.
// - Normal source code in bits 4:0, reset zero.
// - Fast source code in bits 4:0, reset zero.
// - Source read clears edge line's pending bit.
// - Acknowledge bit 0 drops and re-arms normal output.
// - Acknowledge bit 1 drops and re-arms fast output.
// - Per-line config words from 0x1C, priority 6:2.
// - Config bit 1 selects falling edge or low level.
// - Config bit 0 routes line to normal or fast.
// - Software trigger rising bit fires edge lines only.
// - Trigger reads zero and is never self-cleared.
// - Trigger merged with pin request before masking.
// - Global disable bit stops handling, shows status.
// - Idle and wake handshake with the clock manager.
// - Equal priority ties go to the higher line.
// - New request only while output inactive, loads code.
// - All registers are 32-bit words on the port.
module l2ih_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Request pins, active low
  input wire logic [31:0] line_b_in,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Processor outputs
  output logic normal_irq,
  output logic fast_irq,
  output logic handler_disabled_out,
  // Clock manager handshake
  input wire logic idle_req,
  output logic idle_ack,
  output logic wake_req
);
  // ==========================================================
  // Declarations
  logic [31:0] line_low;
  logic [31:0] line_fall;
  logic [31:0] pend_q, pend_d;
  logic [31:0] mask_q, mask_d;
  logic [31:0] swt_q, swt_d;
  logic [31:0] swt_prev_q, swt_prev_d;
  logic gdis_q, gdis_d;
  l2ih_pkg::l2ih_cfg_t cfg_q [32];
  l2ih_pkg::l2ih_cfg_t cfg_d [32];
  logic nact_q, nact_d;
  logic fact_q, fact_d;
  logic [4:0] ncode_q, ncode_d;
  logic [4:0] fcode_q, fcode_d;
  logic [31:0] rdata_q, rdata_d;
  logic idle_ack_q, idle_ack_d;
  logic [31:0] sens_lvl;
  logic [31:0] fast_rt;
  logic [31:0] set_evt;
  logic [31:0] unmasked;
  logic [31:0] rd_clr;
  logic [7:0] cfg_off;
  logic [4:0] cfg_idx;
  logic cfg_hit;
  logic wr_pend, wr_mask, wr_ack, wr_swt, wr_gdis, wr_cfg;
  logic rd_nsrc, rd_fsrc;

  l2ih_res_if nres ();
  l2ih_res_if fres ();

  // ==========================================================
  // Submodules
  // Pin synchroniser and edge detector.
  l2ih_line_sync u_sync (
    .ref_clk (ref_clk),
    .rst_b (rst_b),
    .line_b_in (line_b_in),
    .line_low (line_low),
    .line_fall (line_fall)
  );

  // One resolver per output.
  l2ih_resolver u_nres (
    .res (nres.resolver)
  );

  l2ih_resolver u_fres (
    .res (fres.resolver)
  );

  // ==========================================================
  // Per-line request path
  // Unpack each config word and form the set event of each line.
  for (genvar g = 0; g < l2ih_pkg::LINES; g++)
  begin : g_line
    assign sens_lvl[g] = cfg_q[g][l2ih_pkg::CFG_SENS_BIT];
    assign fast_rt[g] = cfg_q[g][l2ih_pkg::CFG_ROUTE_BIT];
    assign nres.prio[g] = cfg_q[g][l2ih_pkg::CFG_PRIO_MSB:l2ih_pkg::CFG_PRIO_LSB];
    assign fres.prio[g] = cfg_q[g][l2ih_pkg::CFG_PRIO_MSB:l2ih_pkg::CFG_PRIO_LSB];
    // Level lines follow the pin only; edge lines also see the trigger.
    assign set_evt[g] = sens_lvl[g] ? line_low[g] :
                        (line_fall[g] | (swt_q[g] & ~swt_prev_q[g]));
  end

  // Mask sits after the pending flags; routing splits the outputs.
  assign unmasked = pend_q & ~mask_q;
  assign nres.req = unmasked & ~fast_rt;
  assign fres.req = unmasked & fast_rt;

  // ==========================================================
  // Address decode
  // Config words are one per line, four bytes apart.
  assign cfg_off = reg_addr - l2ih_pkg::OFS_CFG0;
  assign cfg_idx = cfg_off[6:2];
  assign cfg_hit = (reg_addr >= l2ih_pkg::OFS_CFG0) && (reg_addr <= l2ih_pkg::OFS_CFG_LAST)
                   && (reg_addr[1:0] == 2'b00);
  assign wr_pend = reg_wr && (reg_addr == l2ih_pkg::OFS_PEND);
  assign wr_mask = reg_wr && (reg_addr == l2ih_pkg::OFS_MASK);
  assign wr_ack = reg_wr && (reg_addr == l2ih_pkg::OFS_ACK);
  assign wr_swt = reg_wr && (reg_addr == l2ih_pkg::OFS_SWT);
  assign wr_gdis = reg_wr && (reg_addr == l2ih_pkg::OFS_GDIS);
  assign wr_cfg = reg_wr && cfg_hit;
  assign rd_nsrc = reg_rd && (reg_addr == l2ih_pkg::OFS_NSRC);
  assign rd_fsrc = reg_rd && (reg_addr == l2ih_pkg::OFS_FSRC);

  // ==========================================================
  // Pending flags
  // Reading a source code clears that line if it is edge-sensitive.
  always_comb
  begin
    rd_clr = 32'h00000000;
    if (rd_nsrc && nact_q && !sens_lvl[ncode_q])
    begin
      rd_clr[ncode_q] = 1'b1;
    end
    if (rd_fsrc && fact_q && !sens_lvl[fcode_q])
    begin
      rd_clr[fcode_q] = 1'b1;
    end
  end

  // Clears apply first so a same-cycle request still lands.
  always_comb
  begin
    pend_d = pend_q;
    if (wr_pend)
    begin
      pend_d = pend_d & reg_wdata;
    end
    pend_d = pend_d & ~rd_clr;
    pend_d = pend_d | set_evt;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_q <= l2ih_pkg::RST_PEND;
    end
    else
    begin
      pend_q <= pend_d;
    end
  end

  // ==========================================================
  // Software-written configuration
  // Mask, trigger, global disable and per-line config words.
  always_comb
  begin
    mask_d = mask_q;
    swt_d = swt_q;
    swt_prev_d = swt_q;
    gdis_d = gdis_q;
    cfg_d = cfg_q;
    if (wr_mask)
    begin
      mask_d = reg_wdata;
    end
    if (wr_swt)
    begin
      swt_d = reg_wdata;
    end
    if (wr_gdis)
    begin
      gdis_d = reg_wdata[l2ih_pkg::GDIS_BIT];
    end
    if (wr_cfg)
    begin
      cfg_d[cfg_idx] = reg_wdata[l2ih_pkg::CFG_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask_q <= l2ih_pkg::RST_MASK;
      swt_q <= l2ih_pkg::RST_SWT;
      swt_prev_q <= l2ih_pkg::RST_SWT;
      gdis_q <= 1'b0;
      for (int i = 0; i < l2ih_pkg::LINES; i++)
      begin
        cfg_q[i] <= l2ih_pkg::RST_CFG;
      end
    end
    else
    begin
      mask_q <= mask_d;
      swt_q <= swt_d;
      swt_prev_q <= swt_prev_d;
      gdis_q <= gdis_d;
      cfg_q <= cfg_d;
    end
  end

  // ==========================================================
  // Output requests
  // Acknowledge drops the output and clears its code; a new winner
  // is only taken while the output is idle and handling is enabled.
  always_comb
  begin
    nact_d = nact_q;
    ncode_d = ncode_q;
    fact_d = fact_q;
    fcode_d = fcode_q;
    if (wr_ack && reg_wdata[l2ih_pkg::ACK_NORM_BIT])
    begin
      nact_d = 1'b0;
      ncode_d = l2ih_pkg::RST_CODE;
    end
    else if (!nact_q && nres.hit && !gdis_q)
    begin
      nact_d = 1'b1;
      ncode_d = nres.code;
    end
    if (wr_ack && reg_wdata[l2ih_pkg::ACK_FAST_BIT])
    begin
      fact_d = 1'b0;
      fcode_d = l2ih_pkg::RST_CODE;
    end
    else if (!fact_q && fres.hit && !gdis_q)
    begin
      fact_d = 1'b1;
      fcode_d = fres.code;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nact_q <= 1'b0;
      ncode_q <= l2ih_pkg::RST_CODE;
      fact_q <= 1'b0;
      fcode_q <= l2ih_pkg::RST_CODE;
    end
    else
    begin
      nact_q <= nact_d;
      ncode_q <= ncode_d;
      fact_q <= fact_d;
      fcode_q <= fcode_d;
    end
  end

  // ==========================================================
  // Read data
  // Read data is captured on the read strobe; unmapped reads give zero.
  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      rdata_d = 32'h00000000;
      if (cfg_hit)
      begin
        rdata_d[l2ih_pkg::CFG_W-1:0] = cfg_q[cfg_idx];
      end
      else
      begin
        case (reg_addr)
          l2ih_pkg::OFS_PEND: rdata_d = pend_q;
          l2ih_pkg::OFS_MASK: rdata_d = mask_q;
          l2ih_pkg::OFS_NSRC: rdata_d[l2ih_pkg::CODE_W-1:0] = ncode_q;
          l2ih_pkg::OFS_FSRC: rdata_d[l2ih_pkg::CODE_W-1:0] = fcode_q;
          l2ih_pkg::OFS_GDIS: rdata_d[l2ih_pkg::GDIS_BIT] = gdis_q;
          l2ih_pkg::OFS_SWT: rdata_d = 32'h00000000;
          default: rdata_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q <= 32'h00000000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Clock manager handshake
  // The acknowledge follows the request one cycle later.
  always_comb
  begin
    idle_ack_d = idle_req;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_ack_q <= 1'b0;
    end
    else
    begin
      idle_ack_q <= idle_ack_d;
    end
  end

  // ==========================================================
  // Outputs
  // The normal and fast outputs are gated by the global disable.
  assign normal_irq = nact_q & ~gdis_q;
  assign fast_irq = fact_q & ~gdis_q;
  assign handler_disabled_out = gdis_q;
  assign reg_rdata = rdata_q;
  assign idle_ack = idle_ack_q;
  // Ask for the clock back while idled if unmasked work is waiting.
  assign wake_req = idle_ack_q & (|(unmasked | (line_low & ~mask_q)));
endmodule // l2ih_top

// File: common/l2ih_pkg.sv
// Constants for the 32-line second-level interrupt handler.
// Assumes a byte-addressed private register port with 32-bit words.
package l2ih_pkg;
  // ==========================================================
  // Sizes
  localparam int LINES = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CODE_W = 5;
  localparam int PRIO_W = 5;
  localparam int CFG_W = 7;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_PEND = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_NSRC = 8'h10;
  localparam logic [7:0] OFS_FSRC = 8'h14;
  localparam logic [7:0] OFS_ACK = 8'h18;
  localparam logic [7:0] OFS_CFG0 = 8'h1C;
  localparam logic [7:0] OFS_CFG_LAST = 8'h98;
  localparam logic [7:0] OFS_SWT = 8'h9C;
  localparam logic [7:0] OFS_GDIS = 8'hA0;
  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_PEND = 32'h00000000;
  localparam logic [31:0] RST_MASK = 32'hFFFFFFFF;
  localparam logic [31:0] RST_SWT = 32'h00000000;
  localparam logic [6:0] RST_CFG = 7'h00;
  localparam logic [4:0] RST_CODE = 5'h00;
  // ==========================================================
  // Field positions
  localparam int CFG_ROUTE_BIT = 0;
  localparam int CFG_SENS_BIT = 1;
  localparam int CFG_PRIO_LSB = 2;
  localparam int CFG_PRIO_MSB = 6;
  localparam int ACK_NORM_BIT = 0;
  localparam int ACK_FAST_BIT = 1;
  localparam int GDIS_BIT = 0;
  // One line's configuration word.
  typedef logic [6:0] l2ih_cfg_t;
endpackage

// File: common/l2ih_res_if.sv
// Carrier between the handler core and one priority resolver.
// Assumes the resolver is purely combinational.
interface l2ih_res_if;
  logic [31:0] req;
  logic [31:0][4:0] prio;
  logic hit;
  logic [4:0] code;
  // The core offers candidate lines, the resolver names the winner.
  modport owner (output req, output prio, input hit, input code);
  modport resolver (input req, input prio, output hit, output code);
endinterface

// File: src/l2ih_resolver.sv
// Priority resolver: picks the winning request among 32 lines.
// Assumes requests are already masked and routed by the caller.
module l2ih_resolver (
  // Candidate lines and winner
  l2ih_res_if.resolver res
);
  logic hit;
  logic [4:0] code;
  logic [4:0] best;

  // Lowest priority value wins; scanning upward lets higher lines win ties.
  always_comb
  begin
    hit = 1'b0;
    code = 5'h00;
    best = 5'h1F;
    for (int i = 0; i < l2ih_pkg::LINES; i++)
    begin
      if (res.req[i] && (!hit || res.prio[i] <= best))
      begin
        hit = 1'b1;
        best = res.prio[i];
        code = i[4:0];
      end
    end
  end

  assign res.hit = hit;
  assign res.code = code;
endmodule // l2ih_resolver

// File: src/l2ih_line_sync.sv
// Input stage: synchronises the active-low request pins.
// Assumes the pins are asynchronous to ref_clk.
module l2ih_line_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Raw pins, active low
  input wire logic [31:0] line_b_in,
  // Synchronised results
  output logic [31:0] line_low,
  output logic [31:0] line_fall
);
  logic [31:0] meta_q, meta_d;
  logic [31:0] sync_q, sync_d;
  logic [31:0] last_q, last_d;

  // Next values: two-stage synchroniser and a history stage.
  always_comb
  begin
    meta_d = line_b_in;
    sync_d = meta_q;
    last_d = sync_q;
  end

  // Idle pins are high, so all stages reset high.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= 32'hFFFFFFFF;
      sync_q <= 32'hFFFFFFFF;
      last_q <= 32'hFFFFFFFF;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // Low level and one-cycle falling-edge pulse.
  assign line_low = ~sync_q;
  assign line_fall = last_q & ~sync_q;
endmodule // l2ih_line_sync

// File: dv/l2ih_sva.sv
// Checker for the handler top ports.
// Assumes one clock ref_clk and async rst_b.
module l2ih_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Outputs and handshake
  input wire logic normal_irq,
  input wire logic fast_irq,
  input wire logic handler_disabled_out,
  input wire logic idle_req,
  input wire logic idle_ack,
  input wire logic wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Acknowledge writes
  sequence ack_n;
    reg_wr && reg_addr == 8'h18 && reg_wdata[0];
  endsequence
  sequence ack_f;
    reg_wr && reg_addr == 8'h18 && reg_wdata[1];
  endsequence
  // ==========================================================
  // Properties
  chk_ack_norm: assert property (ack_n |=> !normal_irq ##1 1'h1)
    else $error("normal output kept after ack");
  chk_ack_fast: assert property (ack_f |=> !fast_irq)
    else $error("fast output kept after ack");
  chk_dis_gates: assert property (handler_disabled_out |-> !normal_irq && !fast_irq)
    else $error("output up while disabled");
  chk_gdis_write: assert property (reg_wr && reg_addr == 8'hA0 |=> handler_disabled_out == $past(reg_wdata[0]))
    else $error("disable status wrong");
  chk_zero_read: assert property (reg_rd && (reg_addr == 8'h9C || reg_addr == 8'hFC) |=> reg_rdata == 32'h0)
    else $error("read not zero");
  chk_code_width: assert property (reg_rd && (reg_addr == 8'h10 || reg_addr == 8'h14) |=> reg_rdata[31:5] == 27'h0)
    else $error("source upper bits set");
  chk_irq_hold: assert property (normal_irq && !reg_wr |=> normal_irq)
    else $error("normal output dropped");
  chk_idle_ack: assert property ($rose(idle_req) |=> idle_ack)
    else $error("idle not acknowledged");
  chk_wake_idle: assert property (wake_req |-> idle_ack)
    else $error("wake outside idle");
endmodule // l2ih_chk

bind l2ih_top l2ih_chk u_chk (.ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .normal_irq, .fast_irq, .handler_disabled_out, .idle_req, .idle_ack, .wake_req);

// File: dv/l2ih_cpu_model.sv
// Processor model: counts requests on both outputs.
// Assumes the outputs are levels on ref_clk.
module l2ih_cpu_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Handler outputs
  input wire logic normal_irq,
  input wire logic fast_irq,
  // Taken request counts
  output logic [7:0] n_cnt,
  output logic [7:0] f_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic n_q;
  logic f_q;
  // Each rising request is taken as one interrupt.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      n_q <= 1'h0;
      f_q <= 1'h0;
      n_cnt <= 8'h00;
      f_cnt <= 8'h00;
    end
    else
    begin
      n_q <= normal_irq;
      f_q <= fast_irq;
      n_cnt <= n_cnt + 8'(normal_irq && !n_q);
      f_cnt <= f_cnt + 8'(fast_irq && !f_q);
    end
  end
endmodule // l2ih_cpu_model

// File: dv/level2_interrupt_handler_32_tb_top.sv
// Testbench for the 32-line interrupt handler.
// Assumes the top, checker and processor model are compiled.
module level2_interrupt_handler_32_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic [31:0] line_b_in = 32'hFFFFFFFF;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic idle_req = 1'h0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_v;
  logic normal_irq, fast_irq, handler_disabled_out, idle_ack, wake_req;
  logic [7:0] n_cnt, f_cnt;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  // Clock at 100 MHz.
  always #5 ref_clk = ~ref_clk;
  l2ih_top dut (.ref_clk, .rst_b, .line_b_in, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .normal_irq, .fast_irq, .handler_disabled_out, .idle_req, .idle_ack, .wake_req);
  l2ih_cpu_model cpu (.ref_clk, .rst_b, .normal_irq, .fast_irq, .n_cnt, .f_cnt);
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(negedge ref_clk);
    rd_v = reg_rdata;
  endtask
  // Samples the output at falling edges so a value launched on the
  // current rising edge is never mistaken for the settled one.
  task automatic wait_out(input logic fast);
    int n = 0;
    @(negedge ref_clk);
    while ((fast ? fast_irq : normal_irq) !== 1'h1 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk({31'h0, fast ? fast_irq : normal_irq}, 32'h1);
  endtask
  // Raises the idle request on a rising edge, then checks acknowledge and wake.
  task automatic idle_chk(input logic [31:0] exp);
    @(posedge ref_clk);
    idle_req <= 1'h1;
    repeat (2) @(posedge ref_clk);
    #1 chk({30'h0, idle_ack, wake_req}, exp);
    @(posedge ref_clk);
    idle_req <= 1'h0;
  endtask
  function automatic logic [7:0] cfg(input int n);
    return l2ih_pkg::OFS_CFG0 + 8'(n * 4);
  endfunction
  task automatic pins(input logic [31:0] v, input int n);
    @(posedge ref_clk);
    line_b_in <= v;
    repeat (n) @(posedge ref_clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] a[8] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h1C, 8'h98, 8'hA0, 8'hFC};
    foreach (a[i])
    begin
      rd(a[i]);
      chk(rd_v, i == 1 ? 32'hFFFFFFFF : 32'h0);
    end
    idle_chk(32'h2);
    $display("reset test done");
  endtask
  task automatic t_mask;
    pins(32'hFFFFFE7F, 3);
    pins(32'hFFFFFFFF, 4);
    rd(8'h00);
    chk(rd_v, 32'h00000180);
    chk({31'h0, normal_irq}, 32'h0);
    wr(8'h00, 32'hFFFFFF7F);
    rd(8'h00);
    chk(rd_v, 32'h00000100);
    wr(8'h00, 32'h0);
    $display("mask test done");
  endtask
  task automatic t_edge;
    wr(cfg(5), 32'h0C);
    wr(8'h04, 32'hFFFFFFDF);
    pins(32'hFFFFFFDF, 0);
    wait_out(1'h0);
    pins(32'hFFFFFFFF, 0);
    rd(8'h10);
    chk(rd_v, 32'h5);
    rd(cfg(5));
    chk(rd_v, 32'h0C);
    rd(8'h00);
    chk(rd_v, 32'h0);
    wr(8'h18, 32'h1);
    @(negedge ref_clk);
    chk({31'h0, normal_irq}, 32'h0);
    rd(8'h10);
    chk(rd_v, 32'h0);
    $display("edge test done");
  endtask
  task automatic t_prio;
    logic [4:0] w[3] = '{5'h03, 5'h14, 5'h09};
    wr(cfg(3), 32'h05);
    wr(cfg(9), 32'h09);
    wr(cfg(20), 32'h09);
    wr(8'h04, 32'hFFEFFDF7);
    wr(8'h9C, 32'h00100208);
    rd(8'h9C);
    chk(rd_v, 32'h0);
    foreach (w[i])
    begin
      wait_out(1'h1);
      rd(8'h14);
      chk(rd_v, {27'h0, w[i]});
      wr(8'h18, 32'h2);
    end
    @(negedge ref_clk);
    chk({30'h0, normal_irq, fast_irq}, 32'h0);
    $display("priority test done");
  endtask
  task automatic t_level;
    wr(cfg(12), 32'h06);
    wr(8'h04, 32'hFFFFEFFF);
    wr(8'h9C, 32'h0);
    wr(8'h9C, 32'h00001000);
    repeat (4) @(posedge ref_clk);
    rd(8'h00);
    chk(rd_v, 32'h0);
    pins(32'hFFFFEFFF, 0);
    wait_out(1'h0);
    rd(8'h10);
    chk(rd_v, 32'h0C);
    rd(8'h00);
    chk(rd_v, 32'h00001000);
    idle_chk(32'h3);
    wr(8'hA0, 32'h1);
    @(negedge ref_clk);
    chk({30'h0, handler_disabled_out, normal_irq}, 32'h2);
    wr(8'hA0, 32'h0);
    pins(32'hFFFFFFFF, 4);
    wr(8'h00, 32'h0);
    wr(8'h18, 32'h1);
    repeat (3) @(negedge ref_clk);
    chk({31'h0, normal_irq}, 32'h0);
    $display("level test done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      test_done;
    end
  end
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'h1;
    t_reset;
    t_mask;
    t_edge;
    t_prio;
    t_level;
    chk({16'h0, n_cnt, f_cnt}, 32'h0303);
    test_done;
  end
endmodule // level2_interrupt_handler_32_tb_top
